// >>> design/pgrc_pkg.sv
package pgrc_pkg;

  // ----------------------------------------
  // Clock and timing
  // ----------------------------------------
  localparam int CLK_FREQ_MHZ = 40;
  localparam int STANDBY_IDLE_NS = 70;
  localparam int POST_RESET_HOLD_NS = 120;
  localparam int WARM_MIN_NS = 150;
  localparam int POR_MIN_MS = 1;
  localparam int FLASH_ABORT_US = 25;
  // Least times round up, longest times round down
  localparam int STANDBY_CYC = (STANDBY_IDLE_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int HOLD_CYC = (POST_RESET_HOLD_NS * CLK_FREQ_MHZ) / 1000;
  localparam int WARM_MIN_CYC = (WARM_MIN_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int POR_MIN_CYC = POR_MIN_MS * CLK_FREQ_MHZ * 1000;
  localparam int FLASH_ABORT_CYC = FLASH_ABORT_US * CLK_FREQ_MHZ;

  // ----------------------------------------
  // Power-mode register zero fields
  // ----------------------------------------
  localparam int PMR_WIDTH = 8;
  localparam logic [7:0] PMR_RESET = 8'h00;
  localparam int PMR0_FAST_OFF_BIT = 3;
  localparam int PMR0_ARRAY_CLK_BLOCK_BIT = 4;
  localparam int PMR0_MC_CLK_BLOCK_BIT = 5;

  // ----------------------------------------
  // Power-mode register two fields
  // ----------------------------------------
  localparam int PMR2_LOW_ADDR_BLOCK_BIT = 0;
  localparam int PMR2_CTRL0_BLOCK_BIT = 2;
  localparam int PMR2_CTRL1_BLOCK_BIT = 3;
  localparam int PMR2_CTRL2_BLOCK_BIT = 4;
  localparam int PMR2_STROBE_BLOCK_BIT = 5;
  localparam int PMR2_HBWE_BLOCK_BIT = 6;

  // ----------------------------------------
  // Memory-mapping register and idle counter
  // ----------------------------------------
  localparam int MAP_WIDTH = 8;
  localparam logic [7:0] MAP_RESET = 8'h00;
  localparam int MAP_SRAM_BIT = 0;
  localparam int MAP_PERIPH_BIT = 7;
  localparam int IDLE_WIDTH = 4;
  localparam logic [3:0] IDLE_LIMIT = 4'hF;

  typedef enum logic [2:0] {RS_COLD, RS_POR, RS_WARM, RS_HOLD, RS_RUN} pgrc_rst_state_t;

endpackage

// >>> design/pgrc_ctl_if.sv
`timescale 1ns/10ps
interface pgrc_ctl_if;
  logic clk_tick;
  logic strobe;
  logic auto_en;
  logic polarity;
  logic wake;
  logic powerdown;
  logic [3:0] idle_count;
  logic pin_low;
  logic por_pulse;
  logic warm_pulse;
  logic in_reset;
  logic cfg_loaded;

  modport idle (input clk_tick, strobe, auto_en, polarity, wake, output powerdown, idle_count);
  modport rstc (input pin_low, output por_pulse, warm_pulse, in_reset, cfg_loaded);
  modport top (output clk_tick, strobe, auto_en, polarity, wake, pin_low,
               input powerdown, idle_count, por_pulse, warm_pulse, in_reset, cfg_loaded);
endinterface

// >>> design/pgrc_idle_counter.sv
`timescale 1ns/10ps
module pgrc_idle_counter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  pgrc_ctl_if.idle ctl
);
  logic strobe_prev_r;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic pd_r;
  logic strobe_edge;
  logic clear_cnt;

  assign strobe_edge = ctl.strobe != strobe_prev_r;
  assign clear_cnt = !ctl.auto_en || strobe_edge || ctl.wake || (ctl.strobe != ctl.polarity);

  always_ff @(posedge clk) begin
    if (rst) begin
      strobe_prev_r <= 1'b0;
    end else begin
      strobe_prev_r <= ctl.strobe;
    end
  end

  always_comb begin
    cnt_nxt = cnt_r;
    if (clear_cnt) begin
      cnt_nxt = 4'h0;
    end else if (ctl.clk_tick && cnt_r != pgrc_pkg::IDLE_LIMIT) begin
      cnt_nxt = cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= 4'h0;
      pd_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      pd_r <= cnt_nxt == pgrc_pkg::IDLE_LIMIT;
    end
  end

  assign ctl.powerdown = pd_r;
  assign ctl.idle_count = cnt_r;

  a_idle_edge_clear: assert property (@(posedge clk) disable iff (rst)
    strobe_edge |=> (cnt_r == 4'h0 && !pd_r)) else $error("idle count survived strobe edge");
  a_idle_pd_after: assert property (@(posedge clk) disable iff (rst)
    $rose(pd_r) |-> ($past(cnt_r) == 4'hE && $past(ctl.clk_tick) && $past(ctl.auto_en)))
    else $error("powerdown raised before fifteen clocks");
endmodule

// >>> design/pgrc_reset_seq.sv
`timescale 1ns/10ps
module pgrc_reset_seq #(
  parameter int POR_MIN = pgrc_pkg::POR_MIN_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  pgrc_ctl_if.rstc ctl
);
  localparam int CW = $clog2(POR_MIN + 1);
  localparam logic [CW-1:0] POR_N = CW'(POR_MIN);
  localparam logic [CW-1:0] WARM_N = CW'(pgrc_pkg::WARM_MIN_CYC);
  localparam logic [CW-1:0] HOLD_N = CW'(pgrc_pkg::HOLD_CYC);
  localparam logic [CW-1:0] ONE = CW'(1);

  pgrc_pkg::pgrc_rst_state_t state_r;
  logic [CW-1:0] cnt_r;
  logic por_r;
  logic warm_r;
  logic in_reset_r;
  logic cfg_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= pgrc_pkg::RS_COLD;
      cnt_r <= '0;
      por_r <= 1'b0;
      warm_r <= 1'b0;
    end else begin
      por_r <= 1'b0;
      warm_r <= 1'b0;
      case (state_r)
        pgrc_pkg::RS_COLD: begin
          if (ctl.pin_low) begin
            state_r <= pgrc_pkg::RS_POR;
            cnt_r <= ONE;
          end
        end
        pgrc_pkg::RS_POR: begin
          if (ctl.pin_low) begin
            if (cnt_r != POR_N) cnt_r <= cnt_r + ONE;
            por_r <= cnt_r == POR_N - ONE;
          end else if (cnt_r == POR_N) begin
            state_r <= pgrc_pkg::RS_HOLD;
            cnt_r <= ONE;
          end else begin
            state_r <= pgrc_pkg::RS_COLD;
          end
        end
        pgrc_pkg::RS_WARM: begin
          if (ctl.pin_low) begin
            if (cnt_r != WARM_N) cnt_r <= cnt_r + ONE;
            warm_r <= cnt_r == WARM_N - ONE;
          end else if (cnt_r == WARM_N) begin
            state_r <= pgrc_pkg::RS_HOLD;
            cnt_r <= ONE;
          end else begin
            state_r <= in_reset_r ? pgrc_pkg::RS_HOLD : pgrc_pkg::RS_RUN;
            cnt_r <= ONE;
          end
        end
        pgrc_pkg::RS_HOLD: begin
          if (ctl.pin_low) begin
            state_r <= pgrc_pkg::RS_WARM;
            cnt_r <= ONE;
          end else if (cnt_r == HOLD_N) begin
            state_r <= pgrc_pkg::RS_RUN;
          end else begin
            cnt_r <= cnt_r + ONE;
          end
        end
        pgrc_pkg::RS_RUN: begin
          if (ctl.pin_low) begin
            state_r <= pgrc_pkg::RS_WARM;
            cnt_r <= ONE;
          end
        end
        default: begin
          state_r <= pgrc_pkg::RS_COLD;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      in_reset_r <= 1'b1;
      cfg_r <= 1'b0;
    end else begin
      if (por_r || warm_r) in_reset_r <= 1'b1;
      else if (state_r == pgrc_pkg::RS_HOLD && cnt_r == HOLD_N && !ctl.pin_low) in_reset_r <= 1'b0;
      if (por_r) cfg_r <= 1'b1;
    end
  end

  assign ctl.por_pulse = por_r;
  assign ctl.warm_pulse = warm_r;
  assign ctl.in_reset = in_reset_r;
  assign ctl.cfg_loaded = cfg_r;

  a_hold_exit_bound: assert property (@(posedge clk) disable iff (rst)
    $fell(ctl.pin_low) && in_reset_r && cfg_r |-> ##[1:6] !in_reset_r || ctl.pin_low)
    else $error("post-reset hold overran");
  a_warm_min_len: assert property (@(posedge clk) disable iff (rst)
    $rose(warm_r) |-> $past(ctl.pin_low, 5)) else $error("warm reset taken on short pulse");
endmodule

// >>> design/pgrc_top.sv
`timescale 1ns/10ps
// ----------------------------------------
// ----------------------------------------
module pgrc_top #(
  parameter int POR_MIN_CYCLES = pgrc_pkg::POR_MIN_CYC
) (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // Device pins
  input wire logic RESET_N,
  input wire logic ADDRESS_STROBE_IN,
  input wire logic DEVICE_CLOCK_IN,
  input wire logic CHIP_SELECT_N,
  input wire logic [7:0] LOW_ADDR,
  input wire logic CONTROL_IN_ZERO,
  input wire logic CONTROL_IN_ONE,
  input wire logic CONTROL_IN_TWO,
  input wire logic HIGH_BYTE_WRITE_ENABLE,
  input wire logic SUPPLY_LOW,
  // Configuration
  input wire logic AUTO_IDLE_SHUTDOWN,
  input wire logic STROBE_POLARITY,
  input wire logic [7:0] MAP_DEFAULT,
  // Register writes
  input wire logic PMR_ZERO_WRITE,
  input wire logic PMR_TWO_WRITE,
  input wire logic MAP_WRITE,
  input wire logic [7:0] REG_WDATA,
  // Flash status
  input wire logic FLASH_BUSY,
  // Register contents
  output logic [7:0] POWER_MODE_REG_ZERO,
  output logic [7:0] POWER_MODE_REG_TWO,
  output logic [7:0] MEMORY_MAP_SELECT_REG,
  // Power state
  output logic POWERDOWN_ACTIVE,
  output logic [3:0] IDLE_COUNT,
  output logic FAST_MODE,
  output logic ARRAY_STANDBY,
  // Logic array inputs
  output logic [7:0] ARRAY_LOW_ADDR,
  output logic [2:0] ARRAY_CONTROL,
  output logic ARRAY_STROBE,
  output logic ARRAY_HIGH_BYTE_WE,
  output logic ARRAY_CLOCK,
  output logic MACROCELL_CLOCK,
  // Memory enables
  output logic PRIMARY_FLASH_EN,
  output logic SECONDARY_FLASH_EN,
  output logic SRAM_EN,
  output logic IO_BLOCK_EN,
  // Reset effects
  output logic DEVICE_IN_RESET,
  output logic GPIO_FORCE_INPUT,
  output logic ADDR_OUT_ENABLE,
  output logic DATA_PORT_ENABLE,
  output logic PERIPH_ENABLE,
  output logic ARRAY_OUT_VALID,
  output logic MACROCELL_CLEAR,
  output logic MACROCELL_USE_EQUATIONS,
  output logic OTHER_REGS_CLEAR,
  // Flash control
  output logic FLASH_ABORT,
  output logic FLASH_FORCE_READ,
  output logic FLASH_WRITE_INHIBIT
);
  localparam logic [2:0] STANDBY_N = 3'(pgrc_pkg::STANDBY_CYC);

  function automatic logic [2:0] sat_inc(input logic [2:0] v, input logic [2:0] lim);
    sat_inc = (v == lim) ? v : v + 3'h1;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [16:0] pin_s1_r;
  logic [16:0] pin_s2_r;
  logic rst_pin_low;
  logic strobe_s;
  logic dclk_s;
  logic cs_n_s;
  logic supply_low_s;
  logic hbwe_s;
  logic [2:0] ctrl_s;
  logic [7:0] addr_s;
  logic dclk_prev_r;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pin_s1_r <= 17'h1_2000;
      pin_s2_r <= 17'h1_2000;
    end else begin
      pin_s1_r <= {RESET_N, ADDRESS_STROBE_IN, DEVICE_CLOCK_IN, CHIP_SELECT_N, SUPPLY_LOW,
                   HIGH_BYTE_WRITE_ENABLE, CONTROL_IN_TWO, CONTROL_IN_ONE, CONTROL_IN_ZERO, LOW_ADDR};
      pin_s2_r <= pin_s1_r;
    end
  end

  assign rst_pin_low = !pin_s2_r[16];
  assign strobe_s = pin_s2_r[15];
  assign dclk_s = pin_s2_r[14];
  assign cs_n_s = pin_s2_r[13];
  assign supply_low_s = pin_s2_r[12];
  assign hbwe_s = pin_s2_r[11];
  assign ctrl_s = pin_s2_r[10:8];
  assign addr_s = pin_s2_r[7:0];

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      dclk_prev_r <= 1'b0;
    end else begin
      dclk_prev_r <= dclk_s;
    end
  end

  // ----------------------------------------
  // Idle counter and reset sequencer
  // ----------------------------------------
  pgrc_ctl_if ctl ();

  assign ctl.clk_tick = dclk_s && !dclk_prev_r;
  assign ctl.strobe = strobe_s;
  assign ctl.auto_en = AUTO_IDLE_SHUTDOWN;
  assign ctl.polarity = STROBE_POLARITY;
  assign ctl.wake = !cs_n_s || rst_pin_low;
  assign ctl.pin_low = rst_pin_low;

  pgrc_idle_counter u_idle (
    .clk(CLOCK),
    .rst(RST),
    .ctl(ctl.idle)
  );

  pgrc_reset_seq #(
    .POR_MIN(POR_MIN_CYCLES)
  ) u_rst (
    .clk(CLOCK),
    .rst(RST),
    .ctl(ctl.rstc)
  );

  logic pd;
  logic in_reset;
  assign pd = ctl.powerdown;
  assign in_reset = ctl.in_reset;
  assign POWERDOWN_ACTIVE = ctl.powerdown;
  assign IDLE_COUNT = ctl.idle_count;
  assign DEVICE_IN_RESET = ctl.in_reset;
  assign ARRAY_OUT_VALID = ctl.cfg_loaded;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] pmr0_r;
  logic [7:0] pmr2_r;
  logic [7:0] map_r;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pmr0_r <= pgrc_pkg::PMR_RESET;
      pmr2_r <= pgrc_pkg::PMR_RESET;
    end else if (ctl.por_pulse) begin
      pmr0_r <= pgrc_pkg::PMR_RESET;
      pmr2_r <= pgrc_pkg::PMR_RESET;
    end else if (!in_reset && !ctl.warm_pulse) begin
      if (PMR_ZERO_WRITE) pmr0_r <= REG_WDATA;
      if (PMR_TWO_WRITE) pmr2_r <= REG_WDATA;
    end
  end

  // map default with two bits cleared
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      map_r <= pgrc_pkg::MAP_RESET;
    end else if (ctl.por_pulse || ctl.warm_pulse) begin
      map_r <= MAP_DEFAULT;
      map_r[pgrc_pkg::MAP_SRAM_BIT] <= 1'b0;
      map_r[pgrc_pkg::MAP_PERIPH_BIT] <= 1'b0;
    end else if (MAP_WRITE && !in_reset) begin
      map_r <= REG_WDATA;
    end
  end

  assign POWER_MODE_REG_ZERO = pmr0_r;
  assign POWER_MODE_REG_TWO = pmr2_r;
  assign MEMORY_MAP_SELECT_REG = map_r;

  // ----------------------------------------
  // Logic array input gating
  // ----------------------------------------
  logic [7:0] arr_addr_r;
  logic [2:0] arr_ctrl_r;
  logic arr_strobe_r;
  logic arr_hbwe_r;
  logic arr_clk_r;
  logic mc_clk_r;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      arr_addr_r <= 8'h00;
      arr_ctrl_r <= 3'h0;
      arr_strobe_r <= 1'b0;
      arr_hbwe_r <= 1'b0;
    end else begin
      arr_addr_r <= addr_s & {8{!pmr2_r[pgrc_pkg::PMR2_LOW_ADDR_BLOCK_BIT] && !pd}};
      arr_ctrl_r[0] <= ctrl_s[0] && !pmr2_r[pgrc_pkg::PMR2_CTRL0_BLOCK_BIT];
      arr_ctrl_r[1] <= ctrl_s[1] && !pmr2_r[pgrc_pkg::PMR2_CTRL1_BLOCK_BIT];
      arr_ctrl_r[2] <= ctrl_s[2] && !pmr2_r[pgrc_pkg::PMR2_CTRL2_BLOCK_BIT];
      arr_strobe_r <= strobe_s && !pmr2_r[pgrc_pkg::PMR2_STROBE_BLOCK_BIT];
      arr_hbwe_r <= hbwe_s && !pmr2_r[pgrc_pkg::PMR2_HBWE_BLOCK_BIT];
    end
  end

  // Gating here does not reach the idle counter, which takes the raw tick
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      arr_clk_r <= 1'b0;
      mc_clk_r <= 1'b0;
    end else begin
      arr_clk_r <= dclk_s && !pmr0_r[pgrc_pkg::PMR0_ARRAY_CLK_BLOCK_BIT];
      mc_clk_r <= dclk_s && !pmr0_r[pgrc_pkg::PMR0_MC_CLK_BLOCK_BIT];
    end
  end

  assign ARRAY_LOW_ADDR = arr_addr_r;
  assign ARRAY_CONTROL = arr_ctrl_r;
  assign ARRAY_STROBE = arr_strobe_r;
  assign ARRAY_HIGH_BYTE_WE = arr_hbwe_r;
  assign ARRAY_CLOCK = arr_clk_r;
  assign MACROCELL_CLOCK = mc_clk_r;

  // ----------------------------------------
  // Array speed and standby
  // ----------------------------------------
  logic [14:0] arr_prev_r;
  logic [14:0] arr_now;
  logic [2:0] stable_r;
  logic standby_r;
  logic fast_r;

  assign arr_now = {arr_addr_r, arr_ctrl_r, arr_strobe_r, arr_hbwe_r, arr_clk_r, mc_clk_r};

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      arr_prev_r <= 15'h0000;
      stable_r <= 3'h0;
      standby_r <= 1'b0;
    end else begin
      arr_prev_r <= arr_now;
      stable_r <= (arr_now != arr_prev_r) ? 3'h0 : sat_inc(stable_r, STANDBY_N);
      standby_r <= pmr0_r[pgrc_pkg::PMR0_FAST_OFF_BIT] && arr_now == arr_prev_r && stable_r >= STANDBY_N - 3'h1;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      fast_r <= 1'b1;
    end else begin
      fast_r <= !pmr0_r[pgrc_pkg::PMR0_FAST_OFF_BIT];
    end
  end

  assign ARRAY_STANDBY = standby_r;
  assign FAST_MODE = fast_r;

  // ----------------------------------------
  // Memory select
  // ----------------------------------------
  logic mem_en_r;
  logic io_en_r;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      mem_en_r <= 1'b0;
      io_en_r <= 1'b0;
    end else begin
      mem_en_r <= !cs_n_s && !pd && !in_reset;
      io_en_r <= !cs_n_s && !in_reset;
    end
  end

  assign PRIMARY_FLASH_EN = mem_en_r;
  assign SECONDARY_FLASH_EN = mem_en_r;
  assign SRAM_EN = mem_en_r;
  assign IO_BLOCK_EN = io_en_r;

  // ----------------------------------------
  // Pin and macrocell reset effects
  // ----------------------------------------
  logic gpio_in_r;
  logic addr_oe_r;
  logic data_oe_r;
  logic mc_clr_r;
  logic mc_eq_r;
  logic other_clr_r;

  // Address out is undefined in power-down; released here for least current
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      gpio_in_r <= 1'b1;
      addr_oe_r <= 1'b0;
      data_oe_r <= 1'b0;
    end else begin
      gpio_in_r <= in_reset;
      addr_oe_r <= !in_reset && !pd;
      data_oe_r <= !in_reset && !pd;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      mc_clr_r <= 1'b0;
      mc_eq_r <= 1'b0;
      other_clr_r <= 1'b0;
    end else begin
      mc_clr_r <= ctl.por_pulse;
      mc_eq_r <= (in_reset && ctl.cfg_loaded) || pd;
      other_clr_r <= ctl.por_pulse || ctl.warm_pulse;
    end
  end

  assign GPIO_FORCE_INPUT = gpio_in_r;
  assign ADDR_OUT_ENABLE = addr_oe_r;
  assign DATA_PORT_ENABLE = data_oe_r;
  assign PERIPH_ENABLE = data_oe_r;
  assign MACROCELL_CLEAR = mc_clr_r;
  assign MACROCELL_USE_EQUATIONS = mc_eq_r;
  assign OTHER_REGS_CLEAR = other_clr_r;

  // ----------------------------------------
  // Flash control
  // ----------------------------------------
  logic abort_r;
  logic force_rd_r;
  logic wr_inh_r;

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      abort_r <= 1'b0;
      force_rd_r <= 1'b1;
      wr_inh_r <= 1'b1;
    end else begin
      abort_r <= rst_pin_low && FLASH_BUSY;
      force_rd_r <= rst_pin_low || in_reset;
      wr_inh_r <= supply_low_s || in_reset;
    end
  end

  assign FLASH_ABORT = abort_r;
  assign FLASH_FORCE_READ = force_rd_r;
  assign FLASH_WRITE_INHIBIT = wr_inh_r;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_pmr_warm_keep: assert property (@(posedge CLOCK) disable iff (RST)
    ctl.warm_pulse |=> $stable(pmr0_r) && $stable(pmr2_r)) else $error("power-mode changed on warm reset");
  a_pmr_por_clear: assert property (@(posedge CLOCK) disable iff (RST)
    ctl.por_pulse |=> pmr0_r == 8'h00 && pmr2_r == 8'h00) else $error("power-mode kept on power-on");
  a_map_reset_bits: assert property (@(posedge CLOCK) disable iff (RST)
    ctl.por_pulse || ctl.warm_pulse |=> !map_r[0] && !map_r[7]) else $error("map bits not cleared");
  a_fast_mode_bit: assert property (@(posedge CLOCK) disable iff (RST)
    ##1 fast_r == !$past(pmr0_r[3])) else $error("fast mode not following bit 3");
  a_chip_select_gate: assert property (@(posedge CLOCK) disable iff (RST)
    cs_n_s |=> !mem_en_r) else $error("memory enabled while deselected");
  a_array_clock_gate: assert property (@(posedge CLOCK) disable iff (RST)
    pmr0_r[4] |=> !arr_clk_r) else $error("array clock not gated");
  a_standby_wait: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(standby_r) |-> $past(arr_now == arr_prev_r, 1) && $past(arr_now == arr_prev_r, 3))
    else $error("standby before quiet interval");
  a_flash_abort_time: assert property (@(posedge CLOCK) disable iff (RST)
    rst_pin_low && FLASH_BUSY |-> ##[1:2] abort_r) else $error("flash cycle not aborted");
  a_reset_pin_state: assert property (@(posedge CLOCK) disable iff (RST)
    in_reset |=> gpio_in_r && !addr_oe_r && !data_oe_r) else $error("pins driven in reset");
  a_array_block_bits: assert property (@(posedge CLOCK) disable iff (RST)
    pmr2_r[0] |=> arr_addr_r == 8'h00) else $error("address byte not blocked");
endmodule

// >>> verif/pgrc_host_model.sv
`timescale 1ns/10ps
module pgrc_host_model (
  // Clock
  input wire logic clk,
  // Bench control
  input wire logic run_clk,
  input wire logic pulse_strobe,
  input wire logic level,
  // Pins
  output logic dev_clk,
  output logic strobe
);
  // ----------------
  // Pin drive
  // ----------------
  logic [1:0] div_r;
  initial begin
    div_r = 2'h0;
    dev_clk = 1'b0;
    strobe = 1'b0;
  end
  always @(posedge clk) begin
    div_r <= div_r + 2'h1;
    dev_clk <= run_clk & div_r[1];
    strobe <= pulse_strobe ? div_r[1] : level;
  end
endmodule

// >>> verif/tb_power_gating_reset_control.sv
`timescale 1ns/10ps
module tb_power_gating_reset_control;
  // ----------------
  // Signals
  // ----------------
  logic clk, rst, rn, csn, hbwe, slow, aen, pol, fb, w0, w2, wm, run, pls, lvl, asi, dci;
  logic pd, fast, sram, inrst, valid, abort, inh, ac, mc, stby, gpi, doe, frd;
  logic [7:0] la, wd, pm0, pm2, map, ala;
  logic [3:0] ic;
  logic [2:0] ct, actl;
  int mismatches, comparisons, i;

  pgrc_host_model host_u (.clk(clk), .run_clk(run), .pulse_strobe(pls), .level(lvl), .dev_clk(dci), .strobe(asi));
  pgrc_top #(.POR_MIN_CYCLES(20)) dut_u (.CLOCK(clk), .RST(rst), .RESET_N(rn), .ADDRESS_STROBE_IN(asi),
    .DEVICE_CLOCK_IN(dci), .CHIP_SELECT_N(csn), .LOW_ADDR(la), .CONTROL_IN_ZERO(ct[0]), .CONTROL_IN_ONE(ct[1]),
    .CONTROL_IN_TWO(ct[2]), .HIGH_BYTE_WRITE_ENABLE(hbwe), .SUPPLY_LOW(slow), .AUTO_IDLE_SHUTDOWN(aen),
    .STROBE_POLARITY(pol), .MAP_DEFAULT(8'hFF), .PMR_ZERO_WRITE(w0), .PMR_TWO_WRITE(w2), .MAP_WRITE(wm),
    .REG_WDATA(wd), .FLASH_BUSY(fb), .POWER_MODE_REG_ZERO(pm0), .POWER_MODE_REG_TWO(pm2),
    .MEMORY_MAP_SELECT_REG(map), .POWERDOWN_ACTIVE(pd), .IDLE_COUNT(ic), .FAST_MODE(fast), .ARRAY_STANDBY(stby),
    .ARRAY_LOW_ADDR(ala), .ARRAY_CONTROL(actl), .ARRAY_STROBE(), .ARRAY_HIGH_BYTE_WE(), .ARRAY_CLOCK(ac),
    .MACROCELL_CLOCK(mc), .PRIMARY_FLASH_EN(), .SECONDARY_FLASH_EN(), .SRAM_EN(sram), .IO_BLOCK_EN(),
    .DEVICE_IN_RESET(inrst), .GPIO_FORCE_INPUT(gpi), .ADDR_OUT_ENABLE(), .DATA_PORT_ENABLE(doe), .PERIPH_ENABLE(),
    .ARRAY_OUT_VALID(valid), .MACROCELL_CLEAR(), .MACROCELL_USE_EQUATIONS(), .OTHER_REGS_CLEAR(),
    .FLASH_ABORT(abort), .FLASH_FORCE_READ(frd), .FLASH_WRITE_INHIBIT(inh));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // ----------------
  // Tasks
  // ----------------
  task finish_test();
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask

  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Bounded wait for a one-bit output to reach a level
  task till(input int sel, input logic v);
    for (i = 0; i < 200 && (sel ? pd : inrst) !== v; i++) wt(1);
    if (i == 200) begin
      mismatches++;
      finish_test();
    end
  endtask

  task wr(input int sel, input logic [7:0] d);
    @(posedge clk);
    w0 <= sel == 0;
    w2 <= sel == 1;
    wm <= sel == 2;
    wd <= d;
    @(posedge clk);
    {w0, w2, wm} <= 3'h0;
  endtask

  // ----------------
  // Sequence
  // ----------------
  initial begin
    {rst, rn, csn, hbwe, slow, aen, pol, fb, w0, w2, wm, run, pls, lvl} = 14'h3800;
    {la, wd, mismatches, comparisons} = '0;
    ct = 3'h1;
    wt(10);
    rst <= 1'b0;
    rn <= 1'b0;
    wt(25);
    rn <= 1'b1;
    wt(3);
    chk("hold", inrst, 1);
    till(0, 0);
    chk("pmr0 por", pm0, 8'h00);
    chk("map por", map, 8'h7E);
    chk("valid", valid, 1);
    wr(0, 8'h38);
    wt(2);
    chk("fast", fast, 0);
    chk("standby", stby, 1);
    chk("gpio input", gpi, 0);
    chk("data enable", doe, 1);
    run <= 1'b1;
    repeat (12) begin
      wt(1);
      chk("clk gate", {ac, mc}, 0);
    end
    wr(1, 8'h7D);
    la <= 8'hFF;
    ct <= 3'h7;
    wt(4);
    chk("addr gate", ala, 0);
    chk("ctl gate", actl, 0);
    ct <= 3'h1;
    csn <= 1'b0;
    wt(4);
    chk("sram on", sram, 1);
    csn <= 1'b1;
    wt(4);
    chk("sram off", sram, 0);
    aen <= 1'b1;
    till(1, 1);
    chk("idle", ic, 8'h0F);
    wt(2);
    chk("data pd", doe, 0);
    pls <= 1'b1;
    till(1, 0);
    chk("wake", ic, 0);
    wr(2, 8'hFF);
    {pls, aen, fb, rn} <= 4'h2;
    wt(8);
    chk("abort", abort, 1);
    chk("force read", frd, 1);
    rn <= 1'b1;
    // Warm reset is triggered by the low time alone, before the pin rises
    till(0, 1);
    till(0, 0);
    chk("pmr0 warm", pm0, 8'h38);
    chk("pmr2 warm", pm2, 8'h7D);
    chk("map warm", map, 8'h7E);
    slow <= 1'b1;
    wt(4);
    chk("inhibit", inh, 1);
    finish_test();
  end
endmodule
